// ### inc/cac_pkg.sv
package cac_pkg;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int NUM_MOD = 5;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_MAX = 8'hff;

  // timebase select codes
  typedef enum logic [1:0] {
    CAC_TB_DIV12 = 2'b00,
    CAC_TB_DIV4 = 2'b01,
    CAC_TB_TMR0 = 2'b10,
    CAC_TB_EXT = 2'b11
  } cac_timebase_t;

  // per-module mode bits
  typedef struct packed {
    logic compare_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_enable;
    logic toggle_enable;
    logic pulse_width_enable;
    logic module_irq_enable;
  } cac_mode_t;

  // array configuration bits
  typedef struct packed {
    logic idle_suspend_bit;
    cac_timebase_t timebase;
    logic overflow_irq_enable;
    logic counter_run_bit;
  } cac_cfg_t;
endpackage

// ### core/cac_module.sv
`timescale 1ns/1ps
// one capture/compare module
module cac_module (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [15:0] count_i,
  input wire cac_pkg::cac_mode_t mode_i,
  input wire logic line_sync_i,
  input wire logic wr_low_i,
  input wire logic wr_high_i,
  input wire logic [7:0] wr_data_i,
  input wire logic flag_clr_i,
  output logic [15:0] value_o,
  output logic line_o,
  output logic flag_o,
  output logic irq_o
);
  logic [7:0] val_lo_q;
  logic [7:0] val_hi_q;
  logic line_prev_q;
  logic out_q;
  logic flag_q;
  logic rise;
  logic fall;
  logic capture;
  logic match16;
  logic pwm_mode;
  logic low_wrap;
  logic match_hit;

  assign rise = line_sync_i & ~line_prev_q;
  assign fall = ~line_sync_i & line_prev_q;
  // capture on selected edges, both when both set
  assign capture = run_i & ((mode_i.rising_capture_enable & rise) |
                   (mode_i.falling_capture_enable & fall));
  assign pwm_mode = mode_i.compare_enable & mode_i.pulse_width_enable;
  assign match16 = tick_i & mode_i.compare_enable &
                   ({val_hi_q, val_lo_q} == count_i);
  assign match_hit = match16 & mode_i.match_enable & ~pwm_mode;
  assign low_wrap = tick_i & (count_i[7:0] == cac_pkg::BYTE_MAX);

  // edge detector history
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      line_prev_q <= 1'b0;
    end else if (run_i) begin
      line_prev_q <= line_sync_i;
    end
  end

  // value register: capture, pwm reload, software writes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      val_lo_q <= 8'h00;
      val_hi_q <= 8'h00;
    end else begin
      if (capture) begin
        val_lo_q <= count_i[7:0];
        val_hi_q <= count_i[15:8];
      end else if (pwm_mode && low_wrap) begin
        val_lo_q <= val_hi_q;
      end else if (wr_low_i) begin
        val_lo_q <= wr_data_i;
      end
      if (wr_high_i && !capture) begin
        val_hi_q <= wr_data_i;
      end
    end
  end

  // output line: toggle or pwm waveform
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      out_q <= 1'b0;
    end else if (pwm_mode && tick_i) begin
      if (count_i[7:0] == cac_pkg::BYTE_MAX) begin
        out_q <= 1'b0;
      end else if (count_i[7:0] + 8'h01 == val_lo_q) begin
        out_q <= 1'b1;
      end
    end else if (match16 && mode_i.match_enable &&
                 mode_i.toggle_enable) begin
      out_q <= ~out_q;
    end
  end

  // sticky event flag, set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      flag_q <= 1'b0;
    end else if (capture || match_hit) begin
      flag_q <= 1'b1;
    end else if (flag_clr_i) begin
      flag_q <= 1'b0;
    end
  end

  assign value_o = {val_hi_q, val_lo_q};
  assign line_o = out_q;
  assign flag_o = flag_q;
  assign irq_o = flag_q & mode_i.module_irq_enable;

  chk_flag_on_capture: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) capture |=> flag_q)
    else $error("flag not set after capture");
  chk_capture_value: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) capture && !wr_high_i
    |=> value_o == $past(count_i))
    else $error("captured value wrong");
  chk_pwm_reload: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) pwm_mode && low_wrap && !capture
    |=> val_lo_q == $past(val_hi_q))
    else $error("pwm reload missing");
  chk_toggle_match: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) match16 && mode_i.match_enable &&
    mode_i.toggle_enable && !pwm_mode |=> out_q != $past(out_q))
    else $error("toggle missing");
endmodule

// ### core/cac_array.sv
`timescale 1ns/1ps
// Operation
// - one 16-bit counter shared by five capture/compare modules, each own line
// - timebase select: clk/12, clk/4, timer0 overflow, external falling edge
// - each module independently capture, timer, toggle output or pwm
// - capture copies the counter into the module value register
// - rising, falling or both edges select the capture trigger
// - capture sets the module flag; hardware never clears it
// - compare and match enables: equality sets the module flag
// - toggle, match, compare enables: each match inverts the line
// - pwm line set on low byte match, cleared on low byte overflow
// - pwm low byte wrap reloads value low byte from high byte
// - compare enable plus pwm enable selects pwm mode
// - reading counter low byte snapshots the high byte for later reads
// - counter byte reads never disturb counting
// - counter wrap sets overflow flag, request when overflow irq enabled
// - overflow flag stays set until software clears it
// - per-module irq enable gates the module flag request
// - requests need global and array interrupt enables set
// - idle suspend clear: operation continues while core idles
// - idle suspend set: operation halts while core idles
// - run bit enables counting when set, halts when clear
module cac_array #(
  parameter int NUM_MOD = cac_pkg::NUM_MOD
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire cac_pkg::cac_cfg_t cfg_i,
  input wire cac_pkg::cac_mode_t [NUM_MOD-1:0] mode_i,
  input wire logic core_idle_i,
  input wire logic tmr0_ovf_i,
  input wire logic external_count_input_i,
  input wire logic [NUM_MOD-1:0] module_io_line_i,
  input wire logic global_irq_enable_i,
  input wire logic array_irq_enable_i,
  input wire logic rd_low_i,
  input wire logic [NUM_MOD-1:0] wr_val_low_i,
  input wire logic [NUM_MOD-1:0] wr_val_high_i,
  input wire logic [7:0] wr_data_i,
  input wire logic ovf_flag_clr_i,
  input wire logic [NUM_MOD-1:0] flag_clr_i,
  output logic [7:0] counter_low_byte_o,
  output logic [7:0] counter_high_byte_o,
  output logic [NUM_MOD-1:0][15:0] module_value_o,
  output logic [NUM_MOD-1:0] module_io_line_o,
  output logic [NUM_MOD-1:0] module_event_flag_o,
  output logic counter_overflow_flag_o,
  output logic irq_o
);
  logic [15:0] count_q;
  logic [7:0] snap_q;
  logic [3:0] presc_q;
  logic [1:0] ext_sync_q;
  logic ext_prev_q;
  logic ext_gap_q;
  logic [NUM_MOD-1:0] line_s1_q;
  logic [NUM_MOD-1:0] line_s2_q;
  logic ovf_q;
  logic run;
  logic count_run;
  logic tick;
  logic presc_last;
  logic ext_fall;
  logic [NUM_MOD-1:0] mod_irq;
  logic [3:0] presc_end;

  // counting and capture frozen by clock enable and by idle suspend
  assign run = clk_en_i & ~(cfg_i.idle_suspend_bit & core_idle_i);
  assign count_run = run & cfg_i.counter_run_bit;

  // pin synchronisers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ext_sync_q <= 2'b00;
      line_s1_q <= '0;
      line_s2_q <= '0;
    end else if (clk_en_i) begin
      ext_sync_q <= {ext_sync_q[0], external_count_input_i};
      line_s1_q <= module_io_line_i;
      line_s2_q <= line_s1_q;
    end
  end

  // prescaler for clk/12 and clk/4
  assign presc_end = (cfg_i.timebase == cac_pkg::CAC_TB_DIV12) ?
                     cac_pkg::DIV12_LAST : cac_pkg::DIV4_LAST;
  assign presc_last = (presc_q >= presc_end);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      presc_q <= 4'h0;
    end else if (count_run) begin
      presc_q <= presc_last ? 4'h0 : presc_q + 4'h1;
    end
  end

  // external falling edges, at most one per four clocks
  // pin level is resampled at every prescaler boundary
  assign ext_fall = ext_prev_q & ~ext_sync_q[1] & presc_last;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ext_prev_q <= 1'b0;
      ext_gap_q <= 1'b0;
    end else if (count_run) begin
      if (presc_last || !ext_gap_q) begin
        ext_prev_q <= ext_sync_q[1];
      end
      ext_gap_q <= 1'b1;
    end
  end

  // timebase select
  always_comb begin
    case (cfg_i.timebase)
      cac_pkg::CAC_TB_DIV12: tick = presc_last;
      cac_pkg::CAC_TB_DIV4: tick = presc_last;
      cac_pkg::CAC_TB_TMR0: tick = tmr0_ovf_i;
      default: tick = ext_fall;
    endcase
    tick = tick & count_run;
  end

  // counter, reads never touch it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      count_q <= cac_pkg::CNT_ZERO;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // high byte snapshot on low byte read
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      snap_q <= 8'h00;
    end else if (clk_en_i && rd_low_i) begin
      snap_q <= count_q[15:8];
    end
  end

  // overflow flag, set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ovf_q <= 1'b0;
    end else if (tick && count_q == cac_pkg::CNT_MAX) begin
      ovf_q <= 1'b1;
    end else if (clk_en_i && ovf_flag_clr_i) begin
      ovf_q <= 1'b0;
    end
  end

  // the five modules
  genvar g;
  generate
    for (g = 0; g < NUM_MOD; g++) begin : g_mod
      cac_module u_mod (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .run_i(run),
        .tick_i(tick),
        .count_i(count_q),
        .mode_i(mode_i[g]),
        .line_sync_i(line_s2_q[g]),
        .wr_low_i(clk_en_i & wr_val_low_i[g]),
        .wr_high_i(clk_en_i & wr_val_high_i[g]),
        .wr_data_i(wr_data_i),
        .flag_clr_i(clk_en_i & flag_clr_i[g]),
        .value_o(module_value_o[g]),
        .line_o(module_io_line_o[g]),
        .flag_o(module_event_flag_o[g]),
        .irq_o(mod_irq[g])
      );
    end
  endgenerate

  assign counter_low_byte_o = count_q[7:0];
  assign counter_high_byte_o = snap_q;
  assign counter_overflow_flag_o = ovf_q;
  // interrupt gating
  assign irq_o = global_irq_enable_i & array_irq_enable_i &
                 ((ovf_q & cfg_i.overflow_irq_enable) | (|mod_irq));

  chk_count_step: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) tick |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter step wrong");
  chk_count_halt: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) !cfg_i.counter_run_bit |=> $stable(count_q))
    else $error("counter moved while halted");
  chk_idle_hold: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) cfg_i.idle_suspend_bit && core_idle_i
    |=> $stable(count_q) && $stable(ovf_q))
    else $error("counter moved in idle suspend");
  chk_ovf_set: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) tick && count_q == cac_pkg::CNT_MAX
    |=> ovf_q && count_q == cac_pkg::CNT_ZERO)
    else $error("overflow flag not set");
  chk_ovf_sticky: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) ovf_q && !ovf_flag_clr_i |=> ovf_q)
    else $error("overflow flag dropped");
  chk_snap_hold: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) clk_en_i && rd_low_i
    |=> counter_high_byte_o == $past(count_q[15:8]))
    else $error("snapshot wrong");
  chk_div4_rate: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) tick && cfg_i.timebase == cac_pkg::CAC_TB_DIV4
    |=> !tick [*3])
    else $error("div4 ticks too close");
  chk_irq_gate: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) !global_irq_enable_i |-> !irq_o)
    else $error("irq without global enable");
endmodule

// ### testbench/cac_pin_model.sv
`timescale 1ns/1ps
// far-side pins: capture sources and external count input
module cac_pin_model (
  input wire logic clk_sys_i,
  output logic [4:0] line_o,
  output logic ext_o
);
  // lines idle low, count input idles high
  initial begin
    line_o = 5'h00;
    ext_o = 1'b1;
  end
  // one pin level change, then time for sync and capture
  task automatic set_line(input int m, input logic v);
    @(posedge clk_sys_i);
    line_o[m] <= v;
    repeat (6) @(posedge clk_sys_i);
    #1;
  endtask
  // falling edges spaced well below the clk/4 rate limit
  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      ext_o <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      ext_o <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
    end
  endtask
endmodule

// ### testbench/cac_array_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the counter array
module cac_array_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  cac_pkg::cac_cfg_t cfg = 5'h00;
  cac_pkg::cac_mode_t [4:0] mode = '0;
  logic idle = 1'b0;
  logic tmr = 1'b0;
  logic gie = 1'b0;
  logic aie = 1'b0;
  logic rd = 1'b0;
  logic cen = 1'b1;
  logic [4:0] wlo = 5'h00;
  logic [4:0] whi = 5'h00;
  logic [7:0] wd = 8'h00;
  logic oclr = 1'b0;
  logic [4:0] fclr = 5'h00;
  logic [4:0] line, lout, flag;
  logic ext, ovf, irq;
  logic [7:0] clo, chi;
  logic [4:0][15:0] val;
  logic [15:0] ecnt = 16'h0000;
  logic [15:0] cnt_rd, v0;
  logic [6:0] capm [3] = '{7'h21, 7'h11, 7'h31};
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;

  cac_pin_model pins (.clk_sys_i(clk_sys_i), .line_o(line), .ext_o(ext));

  cac_array dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(cen),
    .cfg_i(cfg), .mode_i(mode), .core_idle_i(idle), .tmr0_ovf_i(tmr),
    .external_count_input_i(ext), .module_io_line_i(line),
    .global_irq_enable_i(gie), .array_irq_enable_i(aie), .rd_low_i(rd),
    .wr_val_low_i(wlo), .wr_val_high_i(whi), .wr_data_i(wd),
    .ovf_flag_clr_i(oclr), .flag_clr_i(fclr), .counter_low_byte_o(clo),
    .counter_high_byte_o(chi), .module_value_o(val),
    .module_io_line_o(lout), .module_event_flag_o(flag),
    .counter_overflow_flag_o(ovf), .irq_o(irq)
  );

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic settle();
    @(posedge clk_sys_i);
    #1;
  endtask

  // n timer 0 ticks; k says whether the count should follow
  task automatic step(input int n, input logic k);
    @(posedge clk_sys_i);
    tmr <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    tmr <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    if (k)
      ecnt = ecnt + 16'(n);
  endtask

  // low byte read, snapshot seen next cycle
  task automatic rd_cnt();
    @(posedge clk_sys_i);
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    cnt_rd = {chi, clo};
  endtask

  task automatic wr(input int m, input logic hi, input logic [7:0] d);
    @(posedge clk_sys_i);
    wd <= d;
    if (hi)
      whi[m] <= 1'b1;
    else
      wlo[m] <= 1'b1;
    @(posedge clk_sys_i);
    whi <= 5'h00;
    wlo <= 5'h00;
  endtask

  task automatic fclear(input logic [4:0] f, input logic o);
    @(posedge clk_sys_i);
    fclr <= f;
    oclr <= o;
    @(posedge clk_sys_i);
    fclr <= 5'h00;
    oclr <= 1'b0;
    settle();
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      complete_run();
    end
  end

  // test sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd_cnt();
    chk("reset", 16'h0000, {9'h000, ovf, flag, irq});
    $display("test reset done");
    cfg <= 5'h0b;
    gie <= 1'b1;
    aie <= 1'b1;
    step(300, 1);
    rd_cnt();
    chk("count", 16'h012c, cnt_rd);
    step(256, 1);
    chk("snapshot", 16'h012c, {chi, clo});
    cfg.counter_run_bit <= 1'b0;
    step(10, 0);
    rd_cnt();
    chk("halted", ecnt, cnt_rd);
    cfg <= 5'h1b;
    idle <= 1'b1;
    step(5, 0);
    rd_cnt();
    chk("suspended", ecnt, cnt_rd);
    cfg.idle_suspend_bit <= 1'b0;
    step(5, 1);
    rd_cnt();
    chk("idle_run", ecnt, cnt_rd);
    idle <= 1'b0;
    // clock enable low freezes the counter
    cen <= 1'b0;
    step(5, 0);
    cen <= 1'b1;
    rd_cnt();
    chk("frozen", ecnt, cnt_rd);
    $display("test counting done");
    for (int i = 0; i < 3; i++) begin
      cfg.timebase <= cac_pkg::cac_timebase_t'(i == 2 ? 3 : i);
      repeat (30) @(posedge clk_sys_i);
      rd_cnt();
      v0 = cnt_rd;
      if (i == 2)
        pins.ext_edges(3);
      else
        repeat (46) @(posedge clk_sys_i);
      rd_cnt();
      chk("ticks", i == 0 ? 16'h0004 : (i == 1 ? 16'h000c : 16'h0003),
          cnt_rd - v0);
    end
    cfg.timebase <= cac_pkg::CAC_TB_TMR0;
    rd_cnt();
    ecnt = cnt_rd;
    $display("test timebase done");
    chk("ovf_clear", 16'h0000, {15'h0000, ovf});
    step(65536 - int'(ecnt), 1);
    chk("ovf_set", 16'h0003, {14'h0000, ovf, irq});
    gie <= 1'b0;
    settle();
    chk("irq_gie", 16'h0000, {15'h0000, irq});
    gie <= 1'b1;
    cfg.overflow_irq_enable <= 1'b0;
    settle();
    chk("irq_ecf", 16'h0000, {15'h0000, irq});
    step(1, 1);
    chk("ovf_sticky", 16'h0001, {15'h0000, ovf});
    fclear(5'h00, 1'b1);
    chk("ovf_cleared", 16'h0000, {15'h0000, ovf});
    $display("test overflow done");
    step(52, 1);
    for (int m = 0; m < 3; m++) begin
      mode[m] <= capm[m];
      pins.set_line(m, 1'b1);
      chk("rise", {14'h0000, capm[m][5], capm[m][5]},
          {14'h0000, flag[m], irq});
      fclear(5'(1 << m), 1'b0);
      pins.set_line(m, 1'b0);
      chk("fall", {15'h0000, capm[m][4]}, {15'h0000, flag[m]});
      chk("capture", ecnt, val[m]);
      fclear(5'(1 << m), 1'b0);
    end
    $display("test capture done");
    v0 = ecnt + 16'h0005;
    mode[3] <= 7'h4c;
    wr(3, 1'b0, v0[7:0]);
    wr(3, 1'b1, v0[15:8]);
    step(6, 1);
    chk("match", 16'h0006, {13'h0000, flag[3], lout[3], irq});
    $display("test compare done");
    mode[4] <= 7'h42;
    wr(4, 1'b1, 8'h40);
    step(256 - int'(ecnt[7:0]), 1);
    chk("reload", 16'h0040, {8'h00, val[4][7:0]});
    step(32, 1);
    chk("pwm_low", 16'h0000, {15'h0000, lout[4]});
    step(48, 1);
    chk("pwm_high", 16'h0001, {15'h0000, lout[4]});
    step(176, 1);
    chk("pwm_wrap", 16'h0000, {15'h0000, lout[4]});
    $display("test pwm done");
    complete_run();
  end
endmodule
